// >>> core/tfp_defines.vh
// Purpose: Constants for the thermal fan PWM controller
// Assumes: Time base derived from clk by a divider; comparator results as digital inputs
// Notes: Analog levels kept as documented figures for reference only
`ifndef TFP_DEFINES_VH
`define TFP_DEFINES_VH
// ============================================================
// Levels in percent of supply
`define TFP_FULL_PCT 70
`define TFP_SPAN_PCT 40
`define TFP_MARGIN_PCT 11
`define TFP_OT_PCT 77
// ============================================================
// Timing
`define TFP_CLK_HZ 20000000
`define TFP_TB_HZ 30
`define TFP_TB_DIV (`TFP_CLK_HZ / `TFP_TB_HZ)
`define TFP_RESET_US 30
`define TFP_RESET_CYC ((`TFP_RESET_US * (`TFP_CLK_HZ / 1000000)))
`define TFP_KICK_PERIODS 7'h40
`define TFP_DUTY_STEPS 8'hFF
`define TFP_RAMP_LEN 256
`endif

// >>> core/tfp_fan_ctrl.v
// Purpose: Fan PWM control state machine with sleep, kick and fault
// Assumes: Analog compares arrive as digital levels from comparators
// Notes: Duty comes in as an 8-bit code of the controlling input
`timescale 1ns/1ns
`include "tfp_defines.vh"
module tfp_fan_ctrl #(
  parameter TB_DIV = `TFP_TB_DIV
) (
  input wire clk,
  input wire nrst,
  input wire shutdown_level,
  input wire restart_level,
  input wire prim_above_sleep,
  input wire sec_above_sleep,
  input wire prim_above_rouse,
  input wire sec_above_rouse,
  input wire prim_above_full,
  input wire prim_above_ot,
  input wire [7:0] primary_control_input,
  input wire [7:0] secondary_control_input,
  output reg fan_drive,
  output wire fan_drive_oe_n,
  output wire overtemp_fault_n_o,
  output wire overtemp_fault_n_oe_n,
  output wire sleeping,
  output wire kicking
);
  // ============================================================
  // States
  localparam [3:0] ST_OFF = 4'b0001;
  localparam [3:0] ST_KICK = 4'b0010;
  localparam [3:0] ST_RUN = 4'b0100;
  localparam [3:0] ST_SLEEP = 4'b1000;

  // ============================================================
  // Synchronised comparator levels and duty codes
  wire [5:0] cmp_s;
  wire [15:0] duty_s;
  tfp_sync #(.W(6)) u_cmp_sync (
    .clk(clk),
    .nrst(nrst),
    .d({prim_above_sleep, sec_above_sleep, prim_above_rouse,
        sec_above_rouse, prim_above_full, prim_above_ot}),
    .q(cmp_s)
  );
  tfp_sync #(.W(16)) u_duty_sync (
    .clk(clk),
    .nrst(nrst),
    .d({primary_control_input, secondary_control_input}),
    .q(duty_s)
  );
  wire p_slp = cmp_s[5];
  wire s_slp = cmp_s[4];
  wire p_rouse = cmp_s[3];
  wire s_rouse = cmp_s[2];
  wire p_full = cmp_s[1];
  wire p_ot = cmp_s[0];

  // ============================================================
  // Shutdown: asynchronous entry, restart needs the higher level
  reg [1:0] sd_sync_r;
  reg run_en_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sd_sync_r <= 2'b00;
    end else begin
      sd_sync_r <= {sd_sync_r[0], restart_level};
    end
  end
  // Shutdown clears at once; release is synchronised so no flop sees
  // a reset edge inside its recovery window
  wire sd_clr_n = nrst & shutdown_level;
  reg [1:0] core_rst_r;
  always @(posedge clk or negedge sd_clr_n) begin
    if (!sd_clr_n) begin
      core_rst_r <= 2'b00;
    end else begin
      core_rst_r <= {core_rst_r[0], 1'b1};
    end
  end
  wire core_rst_n = core_rst_r[1];
  // Run enable set only after restart seen
  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      run_en_r <= 1'b0;
    end else if (sd_sync_r[1]) begin
      run_en_r <= 1'b1;
    end
  end

  // ============================================================
  // Time base shared by logic and PWM
  wire tick;
  wire tb_run;
  tfp_timebase #(.DIV(TB_DIV)) u_tb (
    .clk(clk),
    .nrst(core_rst_n),
    .run(tb_run),
    .tick(tick)
  );

  // ============================================================
  // Duty selection
  function [7:0] max8;
    input [7:0] a;
    input [7:0] b;
    begin
      max8 = (a > b) ? a : b;
    end
  endfunction
  // Codes are multi-bit words: one is taken only when it reads the same
  // twice, so a code caught between two values never reaches the compare
  reg [15:0] duty_last_r;
  reg [15:0] duty_good_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      duty_last_r <= 16'h0000;
      duty_good_r <= 16'h0000;
    end else begin
      duty_last_r <= duty_s;
      if (duty_s == duty_last_r) begin
        duty_good_r <= duty_s;
      end
    end
  end
  wire [7:0] duty_code = max8(duty_good_r[15:8], duty_good_r[7:0]);

  // ============================================================
  // State machine
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [6:0] kick_r;
  reg [7:0] ramp_r;
  wire any_above_sleep = p_slp | s_slp;
  wire any_rouse = p_rouse | s_rouse;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        // Fresh reset waits for the rouse level before kicking
        if (run_en_r && any_rouse) begin
          state_nxt = ST_KICK;
        end
      end
      ST_KICK: begin
        if (tick && kick_r == `TFP_KICK_PERIODS - 7'h01) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!any_above_sleep) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_rouse) begin
          state_nxt = ST_KICK;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // ============================================================
  // State register and one-hot decode
  function in_state;
    input [3:0] st;
    input [3:0] code;
    begin
      in_state = (st & code) != 4'b0000;
    end
  endfunction

  // Entering the kick restarts the time base, so it lasts 64 whole periods
  wire kick_go = ~in_state(state_r, ST_KICK) & (state_nxt == ST_KICK);
  assign tb_run = run_en_r & ~kick_go;

  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ============================================================
  // Kick length in time-base periods
  reg [6:0] kick_nxt;
  always @* begin
    kick_nxt = kick_r;
    if (!in_state(state_r, ST_KICK)) begin
      kick_nxt = 7'h00;
    end else if (tick) begin
      kick_nxt = kick_r + 7'h01;
    end
  end

  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      kick_r <= 7'h00;
    end else begin
      kick_r <= kick_nxt;
    end
  end

  // ============================================================
  // Ramp: one full sweep per time-base period
  // Large dividers slow the ramp; leftover cycles sit at the top code
  localparam integer RAMP_STEP = (TB_DIV >= `TFP_RAMP_LEN) ? (TB_DIV / `TFP_RAMP_LEN) : 1;
  reg [15:0] step_r;
  reg [7:0] duty_hold_r;
  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ramp_r <= 8'h00;
      step_r <= 16'h0000;
      duty_hold_r <= 8'h00;
    end else if (tick) begin
      // Duty sampled once a period, so each period gives one clean pulse
      ramp_r <= 8'h00;
      step_r <= 16'h0000;
      duty_hold_r <= duty_code;
    end else if (step_r == RAMP_STEP - 1) begin
      step_r <= 16'h0000;
      if (ramp_r != `TFP_DUTY_STEPS && in_state(state_r, ST_RUN)) begin
        ramp_r <= ramp_r + 8'h01;
      end
    end else begin
      step_r <= step_r + 16'h0001;
    end
  end

  // ============================================================
  // Drive and fault outputs
  reg fault_r;
  reg drive_nxt;
  reg fault_nxt;
  wire pwm_on = duty_hold_r > ramp_r;
  always @* begin
    drive_nxt = 1'b0;
    fault_nxt = 1'b0;
    case (state_r)
      ST_KICK: begin
        drive_nxt = 1'b1;
        // Fault watch runs beside the kick, not after it
        fault_nxt = p_ot;
      end
      ST_RUN: begin
        // Overtemp sits above full duty, so fault implies full drive
        drive_nxt = p_full | p_ot | pwm_on;
        fault_nxt = p_ot;
      end
      default: begin
        drive_nxt = 1'b0;
        fault_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      fan_drive <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      fan_drive <= drive_nxt;
      fault_r <= fault_nxt;
    end
  end

  // Fault pin: open drain, enable low pulls the pin low
  assign overtemp_fault_n_o = 1'b0;
  assign overtemp_fault_n_oe_n = ~fault_r;
  // Drive floats in sleep and in shutdown
  assign fan_drive_oe_n = ~core_rst_n | in_state(state_r, ST_SLEEP);
  assign sleeping = in_state(state_r, ST_SLEEP);
  assign kicking = in_state(state_r, ST_KICK);
endmodule // tfp_fan_ctrl

// >>> core/tfp_sync.v
// Purpose: Two-flop synchroniser for a group of comparator levels
// Assumes: Inputs asynchronous to clk
// Notes: First stage read only by second stage
`timescale 1ns/1ns
module tfp_sync #(
  parameter W = 6
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // tfp_sync

// >>> core/tfp_timebase.v
// Purpose: Slow time base tick standing in for the capacitor oscillator
// Assumes: Divider value large; parameter shortens it for simulation
// Notes: Tick is one clk wide once per time-base period
`timescale 1ns/1ns
module tfp_timebase #(
  parameter DIV = 666666
) (
  input wire clk,
  input wire nrst,
  input wire run,
  output reg tick
);
  reg [23:0] cnt_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 24'h00_0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 24'h00_0000;
      tick <= 1'b0;
    end else if (cnt_r >= DIV - 1) begin
      cnt_r <= 24'h00_0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 24'h00_0001;
      tick <= 1'b0;
    end
  end
endmodule // tfp_timebase

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for fan control
// Assumes: TB_DIV 256, one code step a clock
// Notes: Three kicks set the run length
`timescale 1ns/1ns
module tb_top;
  localparam DV = 256;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] pp = 8'h00;
  reg [7:0] sp = 8'h00;
  wire shutdown_level, restart_level, prim_above_sleep, sec_above_sleep, prim_above_rouse;
  wire sec_above_rouse, prim_above_full, prim_above_ot, fan_drive, fan_drive_oe_n;
  wire overtemp_fault_n_o, overtemp_fault_n_oe_n, sleeping, kicking;
  wire [7:0] primary_control_input, secondary_control_input;
  integer mismatches = 0, compares = 0, cyc = 0, n, c;
  always #25 clk = ~clk;
  tfp_sense_model pm (.*);
  tfp_fan_ctrl #(.TB_DIV(DV)) dut (.*);
  task chk(input [31:0] e, input [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %0d", $time, g);
    end
  endtask
  task lv(input [7:0] a, input [7:0] b, input integer w);
    @(posedge clk);
    pp <= a;
    sp <= b;
    repeat (w) @(posedge clk);
    #1;
  endtask
  task kick;
    for (n = 0; n < 40 && kicking !== 1'b1; n = n + 1) lv(pp, sp, 0);
    lv(pp, sp, 1);
    chk(1, fan_drive);
    for (n = 0; n < 70 * DV && kicking === 1'b1; n = n + 1) lv(pp, sp, 0);
    chk(1, n > 62 * DV && n < 65 * DV);
  endtask
  task duty(input integer e);
    c = 0;
    for (n = 0; n < DV; n = n + 1) begin
      lv(pp, sp, 0);
      c = c + fan_drive;
    end
    chk(1, c > e - 12 && c < e + 12);
  endtask
  task t_duty;
    lv(8'h2D, 8'h14, 40);
    chk(0, fan_drive);
    lv(8'h3C, 8'h14, 0);
    kick;
    lv(8'h23, 8'h3C, DV);
    duty(191);
    lv(8'h41, 8'h3C, DV);
    duty(223);
    lv(8'h4B, 8'h14, DV);
    duty(DV);
    lv(8'h4F, 8'h14, 10);
    chk(0, overtemp_fault_n_oe_n);
    lv(8'h3C, 8'h14, DV);
    chk(1, overtemp_fault_n_oe_n);
    duty(191);
    $display("duty test done");
  endtask
  task t_sleep;
    lv(8'h23, 8'h14, 20);
    chk(1, sleeping);
    lv(8'h30, 8'h14, 40);
    chk(1, sleeping);
    lv(8'h30, 8'h37, 0);
    kick;
    $display("sleep test done");
  endtask
  task t_shut;
    lv(8'h4F, 8'h14, 10);
    lv(8'h05, 8'h50, 700);
    chk(1, fan_drive_oe_n & overtemp_fault_n_oe_n);
    lv(8'h3C, 8'h14, 8);
    chk(1, overtemp_fault_n_oe_n);
    lv(8'h4F, 8'h14, 10);
    chk(0, overtemp_fault_n_oe_n);
    kick;
    $display("shutdown test done");
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_duty;
    t_sleep;
    t_shut;
    test_done;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 70000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
endmodule // tb_top

// >>> tb/tfp_checker.sv
// Purpose: Port assertions for fan control
// Assumes: Comparator levels are clean
// Notes: Kick length judged by the bench
`timescale 1ns/1ns
module tfp_checker (
  input wire clk, input wire nrst, input wire shutdown_level, input wire prim_above_ot,
  input wire fan_drive, input wire fan_drive_oe_n, input wire overtemp_fault_n_o,
  input wire overtemp_fault_n_oe_n, input wire kicking, input wire sleeping
);
  wire rel_w = fan_drive_oe_n & overtemp_fault_n_oe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  shut_rel_a: assert property (!shutdown_level |-> rel_w) else $error("shutdown");
  sleep_off_a: assert property (sleeping |-> rel_w) else $error("sleep");
  kick_on_a: assert property (kicking && $past(kicking) |-> fan_drive) else $error("kick");
  ot_full_a: assert property (!overtemp_fault_n_oe_n |-> fan_drive) else $error("full");
  ot_set_a: assert property ((prim_above_ot && fan_drive && !kicking)[*8] |->
    !overtemp_fault_n_oe_n) else $error("fault set");
  ot_clr_a: assert property ((!prim_above_ot)[*6] |-> overtemp_fault_n_oe_n)
    else $error("fault clear");
  ot_pin_a: assert property (!overtemp_fault_n_o) else $error("fault pin");
  restart_clean_a: assert property ($rose(shutdown_level) |-> !kicking && !fan_drive)
    else $error("restart");
endmodule // tfp_checker
bind tfp_fan_ctrl tfp_checker chk_i (.clk, .nrst, .shutdown_level, .prim_above_ot, .fan_drive,
  .fan_drive_oe_n, .overtemp_fault_n_o, .overtemp_fault_n_oe_n, .kicking, .sleeping);

// >>> tb/tfp_sense_model.sv
// Purpose: Sensor networks, percent of supply to comparator levels
// Assumes: Ideal comparators, sleep threshold 39 percent
// Notes: Margins kept clear of every threshold except shutdown, which the bench drives at exactly 5
`timescale 1ns/1ns
module tfp_sense_model (
  input wire [7:0] pp, input wire [7:0] sp, output wire shutdown_level, output wire restart_level,
  output wire prim_above_sleep, output wire sec_above_sleep, output wire prim_above_rouse,
  output wire sec_above_rouse, output wire prim_above_full, output wire prim_above_ot,
  output wire [7:0] primary_control_input, output wire [7:0] secondary_control_input
);
  function [7:0] duty(input [7:0] v);
    duty = v < 8'h1E ? 8'h00 : v > 8'h46 ? 8'hFF : 8'((v - 8'h1E) * 255 / 40);
  endfunction
  assign shutdown_level = pp > 8'h05;
  assign restart_level = pp > 8'h0A;
  assign prim_above_sleep = pp > 8'h27;
  assign sec_above_sleep = sp > 8'h27;
  assign prim_above_rouse = pp > 8'h32;
  assign sec_above_rouse = sp > 8'h32;
  assign prim_above_full = pp > 8'h46;
  assign prim_above_ot = pp > 8'h4D;
  assign primary_control_input = duty(pp);
  assign secondary_control_input = duty(sp);
endmodule // tfp_sense_model
